//--- logic/spel_pkg.sv
// constants and types for the serial port enable and link fault block
package spel_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] SPEL_CTRL_ADDR = 8'h00;
	localparam logic [7:0] SPEL_STATUS_ADDR = 8'h04;
	localparam logic [7:0] SPEL_LATCH_ADDR = 8'h08;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int SPEL_CTRL_LOOP_BIT = 0;
	localparam int SPEL_CTRL_HALF_BIT = 1;
	localparam int SPEL_CTRL_TXCK_LSB = 2;
	localparam int SPEL_CTRL_SPD_LSB = 4;
	localparam int SPEL_CTRL_AMP_LSB = 6;
	localparam int SPEL_CTRL_INSEL_LSB = 8;
	localparam logic [11:0] SPEL_CTRL_RESET = 12'h000;
	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int SPEL_STAT_LFN_LSB = 0;
	localparam int SPEL_STAT_PDN_LSB = 4;
	localparam int SPEL_STAT_CFGERR_BIT = 8;
	// ------------------------------------------------------------
	// latch reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SPEL_OE_RESET = 8'h00;
	localparam logic [7:0] SPEL_BIST_RESET = 8'hff;
	localparam logic [7:0] SPEL_RX_RESET = 8'h00;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SPEL_CHAR_BITS = 10;
	localparam int SPEL_MULT_FULL = 10;
	localparam int SPEL_MULT_HALF = 20;
	localparam int SPEL_NO_TRANS_BITS = 60;
	localparam int SPEL_GOOD_CHARS = 3;
	localparam int SPEL_RANGE_PERIODS = 16000;
	localparam logic [1:0] SPEL_LVL_LOW = 2'h0;
	localparam logic [1:0] SPEL_LVL_MID = 2'h1;
	localparam logic [1:0] SPEL_LVL_HIGH = 2'h2;
	// amplitude class inputs: 0 below 140 mV, 1 >= 140 mV, 2 >= 280 mV, 3 >= 420 mV
	localparam logic [1:0] SPEL_AMP_140 = 2'h1;
	localparam logic [1:0] SPEL_AMP_280 = 2'h2;
	localparam logic [1:0] SPEL_AMP_420 = 2'h3;
	typedef enum logic [1:0] {SPEL_SET_LOW, SPEL_SET_MID, SPEL_SET_HIGH} spel_level_t;
endpackage : spel_pkg

//--- logic/spel_top.sv
// serial driver enables, loopback, rate select and link fault per channel
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module spel_top import spel_pkg::*; #(
	parameter int RANGE_PERIODS = SPEL_RANGE_PERIODS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic test_reset_n,
	input wire logic [7:0] shared_enable_bus,
	input wire logic output_latch_en,
	input wire logic selftest_latch_en,
	input wire logic rx_channel_latch_en,
	input wire logic ref_clock,
	input wire logic [3:0] tx_serial,
	input wire logic [3:0] serial_in_pair_1,
	input wire logic [3:0] serial_in_pair_2,
	input wire logic [7:0] amp_class_1,
	input wire logic [7:0] amp_class_2,
	input wire logic [3:0] vco_in_range,
	output logic [7:0] serial_out_pair,
	output logic [7:0] driver_en,
	output logic [3:0] tx_chan_pwr_dn,
	output logic [3:0] bist_tx_en,
	output logic [3:0] bist_rx_en,
	output logic [3:0] rx_chan_en,
	output logic [3:0] cdr_data,
	output logic [4:0] bit_mult,
	output logic char_tick,
	output logic [3:0] link_fault_n
);
	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [11:0] ctrl_q;
	logic [7:0] oe_q;
	logic [7:0] bist_q;
	logic [7:0] rx_q;
	logic cfg_err;
	logic access;
	logic [31:0] rdata_d;
	logic addr_ok;

	assign access = psel && penable && !pready;

	always_comb begin
		rdata_d = 32'h0000_0000;
		addr_ok = 1'b1;
		unique case (paddr)
			SPEL_CTRL_ADDR: rdata_d[11:0] = ctrl_q;
			SPEL_STATUS_ADDR: begin
				rdata_d[SPEL_STAT_LFN_LSB +: 4] = link_fault_n;
				rdata_d[SPEL_STAT_PDN_LSB +: 4] = tx_chan_pwr_dn;
				rdata_d[SPEL_STAT_CFGERR_BIT] = cfg_err;
			end
			SPEL_LATCH_ADDR: rdata_d[23:0] = {rx_q, bist_q, oe_q};
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && !addr_ok;
			if (access && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= SPEL_CTRL_RESET;
		end else if (psel && penable && pready && pwrite && paddr == SPEL_CTRL_ADDR) begin
			ctrl_q <= pwdata[11:0];
		end
	end

	// ------------------------------------------------------------
	// static configuration decode
	// ------------------------------------------------------------
	logic loopback_select;
	logic ref_half_rate_sel;
	logic [1:0] tx_input_clock_sel;
	logic [3:0] line_input_sel;
	spel_level_t speed_range_sel;
	spel_level_t amplitude_threshold_sel;

	function automatic spel_level_t spel_decode(input logic [1:0] code);
		spel_level_t lvl;
		lvl = SPEL_SET_LOW;
		if (code == SPEL_LVL_MID) begin
			lvl = SPEL_SET_MID;
		end else if (code == SPEL_LVL_HIGH) begin
			lvl = SPEL_SET_HIGH;
		end
		return lvl;
	endfunction : spel_decode

	assign loopback_select = ctrl_q[SPEL_CTRL_LOOP_BIT];
	assign ref_half_rate_sel = ctrl_q[SPEL_CTRL_HALF_BIT];
	assign tx_input_clock_sel = ctrl_q[SPEL_CTRL_TXCK_LSB +: 2];
	assign line_input_sel = ctrl_q[SPEL_CTRL_INSEL_LSB +: 4];
	assign speed_range_sel = spel_decode(ctrl_q[SPEL_CTRL_SPD_LSB +: 2]);
	assign amplitude_threshold_sel = spel_decode(ctrl_q[SPEL_CTRL_AMP_LSB +: 2]);
	// flags half rate with a nonzero tx clock select, and half rate at the reserved low speed
	assign cfg_err = ref_half_rate_sel && (tx_input_clock_sel != SPEL_LVL_LOW
		|| speed_range_sel == SPEL_SET_LOW);

	// ------------------------------------------------------------
	// enable latches on the shared bus
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q <= SPEL_OE_RESET;
		end else if (!test_reset_n) begin
			oe_q <= SPEL_OE_RESET;
		end else if (output_latch_en) begin
			oe_q <= shared_enable_bus;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bist_q <= SPEL_BIST_RESET;
		end else if (!test_reset_n) begin
			bist_q <= SPEL_BIST_RESET;
		end else if (selftest_latch_en) begin
			bist_q <= shared_enable_bus;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= SPEL_RX_RESET;
		end else if (!test_reset_n) begin
			rx_q <= SPEL_RX_RESET;
		end else if (rx_channel_latch_en) begin
			rx_q <= shared_enable_bus;
		end
	end

	// ------------------------------------------------------------
	// transmit clock multiplier
	// ------------------------------------------------------------
	logic [4:0] char_cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_mult <= 5'(SPEL_MULT_FULL);
			char_cnt_q <= 5'h00;
			char_tick <= 1'b0;
		end else begin
			bit_mult <= ref_half_rate_sel ? 5'(SPEL_MULT_HALF) : 5'(SPEL_MULT_FULL);
			char_tick <= char_cnt_q == 5'(SPEL_CHAR_BITS - 1);
			char_cnt_q <= (char_cnt_q == 5'(SPEL_CHAR_BITS - 1)) ? 5'h00 : char_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// reference edge and range control sampling
	// ------------------------------------------------------------
	logic ref_q;
	logic range_sample;
	logic [13:0] range_cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= 1'b0;
			range_cnt_q <= 14'h0000;
		end else begin
			ref_q <= ref_clock;
			if (ref_clock && !ref_q) begin
				range_cnt_q <= range_sample ? 14'h0000 : range_cnt_q + 14'h0001;
			end
		end
	end
	assign range_sample = ref_clock && !ref_q && range_cnt_q == 14'(RANGE_PERIODS - 1);

	// ------------------------------------------------------------
	// per channel transmit, recovery input and link fault
	// ------------------------------------------------------------
	for (genvar ch = 0; ch < 4; ch++) begin : g_ch
		logic sel_bit;
		logic [1:0] amp_class;
		logic [1:0] amp_need;
		logic amp_ok;
		logic [6:0] idle_q;
		logic [3:0] bit_q;
		logic char_trans_q;
		logic [1:0] good_q;
		logic trans_fault_q;
		logic force_q;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				serial_out_pair[2*ch +: 2] <= 2'b00;
				driver_en[2*ch +: 2] <= 2'b00;
				tx_chan_pwr_dn[ch] <= 1'b1;
				bist_tx_en[ch] <= 1'b0;
				bist_rx_en[ch] <= 1'b0;
				rx_chan_en[ch] <= 1'b0;
			end else begin
				driver_en[2*ch +: 2] <= oe_q[2*ch +: 2];
				serial_out_pair[2*ch +: 2] <= oe_q[2*ch +: 2]
					& {2{loopback_select || tx_serial[ch]}};
				tx_chan_pwr_dn[ch] <= oe_q[2*ch +: 2] == 2'b00;
				bist_tx_en[ch] <= !bist_q[2*ch + 1];
				bist_rx_en[ch] <= !bist_q[2*ch];
				rx_chan_en[ch] <= rx_q[2*ch];
			end
		end

		// loopback routes transmit data, otherwise the chosen receiver
		assign sel_bit = loopback_select ? tx_serial[ch]
			: (line_input_sel[ch] ? serial_in_pair_2[ch] : serial_in_pair_1[ch]);
		assign amp_class = line_input_sel[ch] ? amp_class_2[2*ch +: 2] : amp_class_1[2*ch +: 2];

		always_comb begin
			amp_need = SPEL_AMP_140;
			unique case (amplitude_threshold_sel)
				SPEL_SET_LOW: amp_need = SPEL_AMP_140;
				SPEL_SET_MID: amp_need = SPEL_AMP_280;
				SPEL_SET_HIGH: amp_need = SPEL_AMP_420;
				default: amp_need = SPEL_AMP_140;
			endcase
		end
		assign amp_ok = loopback_select || amp_class >= amp_need;

		// transition density monitor on recovered bits
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cdr_data[ch] <= 1'b0;
				idle_q <= 7'h00;
				bit_q <= 4'h0;
				char_trans_q <= 1'b0;
				good_q <= 2'h0;
				trans_fault_q <= 1'b1;
			end else begin
				cdr_data[ch] <= sel_bit;
				if (sel_bit != cdr_data[ch]) begin
					idle_q <= 7'h00;
				end else if (idle_q <= 7'(SPEL_NO_TRANS_BITS)) begin
					idle_q <= idle_q + 7'h01;
				end
				bit_q <= (bit_q == 4'(SPEL_CHAR_BITS - 1)) ? 4'h0 : bit_q + 4'h1;
				if (bit_q == 4'(SPEL_CHAR_BITS - 1)) begin
					char_trans_q <= 1'b0;
					if (char_trans_q || sel_bit != cdr_data[ch]) begin
						good_q <= (good_q == 2'(SPEL_GOOD_CHARS)) ? good_q : good_q + 2'h1;
					end else begin
						good_q <= 2'h0;
					end
				end else if (sel_bit != cdr_data[ch]) begin
					char_trans_q <= 1'b1;
				end
				if (idle_q > 7'(SPEL_NO_TRANS_BITS)) begin
					trans_fault_q <= 1'b1;
					good_q <= 2'h0;
				end else if (good_q == 2'(SPEL_GOOD_CHARS)) begin
					trans_fault_q <= 1'b0;
				end
			end
		end

		// range control forces the oscillator until the next sample
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				force_q <= 1'b0;
				link_fault_n[ch] <= 1'b0;
			end else begin
				if (range_sample) begin
					force_q <= !vco_in_range[ch];
				end
				link_fault_n[ch] <= amp_ok && !trans_fault_q && !force_q
					&& rx_q[2*ch];
			end
		end

		lf_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
			!rx_q[2*ch] |=> !link_fault_n[ch])
			else $error("disabled channel shows valid link");
		lf_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
			force_q |=> !link_fault_n[ch])
			else $error("link valid while range forced");
		lf_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
			idle_q > 7'(SPEL_NO_TRANS_BITS) |=> ##1 !link_fault_n[ch])
			else $error("no fault after idle bits");
		lf_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
			link_fault_n[ch] |-> $past(amp_ok) && $past(rx_q[2*ch]))
			else $error("link valid without amplitude or enable");
		loop_route_a: assert property (@(posedge pclk) disable iff (!presetn)
			loopback_select |=> cdr_data[ch] == $past(tx_serial[ch]))
			else $error("loopback data not routed");
		in_route_a: assert property (@(posedge pclk) disable iff (!presetn)
			!loopback_select && line_input_sel[ch] |=> cdr_data[ch] == $past(serial_in_pair_2[ch]))
			else $error("second receiver not routed");
		loop_out_a: assert property (@(posedge pclk) disable iff (!presetn)
			loopback_select && oe_q[2*ch] |=> serial_out_pair[2*ch])
			else $error("loopback output not one");
		pwr_dn_a: assert property (@(posedge pclk) disable iff (!presetn)
			oe_q[2*ch +: 2] == 2'b00 |=> tx_chan_pwr_dn[ch] && !driver_en[2*ch])
			else $error("channel not powered down");
	end

	oe_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!output_latch_en && test_reset_n |=> $stable(oe_q))
		else $error("output latch changed while closed");
	oe_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		output_latch_en && test_reset_n |=> ##1 driver_en == $past(shared_enable_bus, 2))
		else $error("enable bus not passed to drivers");
	oe_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		!test_reset_n |=> ##1 driver_en == SPEL_OE_RESET)
		else $error("test reset did not disable drivers");
	mult_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		ref_half_rate_sel [*2] |-> bit_mult == 5'(SPEL_MULT_HALF))
		else $error("multiplier not 20 in half rate");

endmodule : spel_top

`default_nettype wire

//--- verif/serial_port_enable_and_link_fault_tb.sv
// testbench for the serial port enable and link fault block
`timescale 1ns/1ps
`default_nettype none
module serial_port_enable_and_link_fault_tb;
	import spel_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, bus = 8'h00, sop, den;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, trst_n = 1'b1, ref_clk = 1'b0, tick_o, tx_tog = 1'b0;
	logic [2:0] le = 3'h0;
	logic [3:0] tx = 4'h0, tx_set = 4'h0, s1, s2, vok, pdn, btx, brx, rxe, cdr, lfn;
	logic [7:0] a1, a2;
	logic [4:0] mult;
	logic tog = 1'b1, lvl = 1'b0, inr = 1'b1;
	logic [1:0] amp = 2'h3;
	logic [2:0] refc = 3'h0;
	int miscompares = 0, compares = 0, ticks;
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		refc <= refc + 3'h1;
		ref_clk <= refc[1];
		tx <= tx_tog ? ~tx : tx_set;
	end
	spel_top #(.RANGE_PERIODS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .test_reset_n(trst_n), .shared_enable_bus(bus),
		.output_latch_en(le[0]), .selftest_latch_en(le[1]), .rx_channel_latch_en(le[2]),
		.ref_clock(ref_clk), .tx_serial(tx), .serial_in_pair_1(s1), .serial_in_pair_2(s2),
		.amp_class_1(a1), .amp_class_2(a2), .vco_in_range(vok), .serial_out_pair(sop),
		.driver_en(den), .tx_chan_pwr_dn(pdn), .bist_tx_en(btx), .bist_rx_en(brx),
		.rx_chan_en(rxe), .cdr_data(cdr), .bit_mult(mult), .char_tick(tick_o),
		.link_fault_n(lfn));
	spel_far_end far (.pclk(pclk), .toggle(tog), .level(lvl), .amp(amp), .in_range(inr),
		.line_1(s1), .line_2(s2), .amp_1(a1), .amp_2(a2), .vco_ok(vok));
	task test_done;
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50)
			check("pready", 0, 1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// pulse one latch enable with a bus value, then let the outputs settle
	task latch(input int w, input logic [7:0] v);
		bus <= v;
		le[w] <= 1'b1;
		tick(2);
		le[w] <= 1'b0;
		tick(3);
	endtask : latch
	initial begin
		#100us;
		miscompares++;
		test_done;
	end
	initial begin
		tick(20);
		presetn <= 1'b1;
		tick(1);
		check("driver_en", den, 8'h00);
		check("pwr_dn", pdn, 4'hf);
		check("mult", mult, 5'd10);
		apb(1'b0, 8'h0c, 0);
		check("slverr", err, 1);
		check("unmapped rd", rd, 0);
		latch(1, 8'h5a);
		check("bist_tx", btx, 4'hc);
		check("bist_rx", brx, 4'h3);
		latch(2, 8'haa);
		check("rx_en odd", rxe, 4'h0);
		latch(2, 8'h55);
		check("rx_en", rxe, 4'hf);
		trst_n <= 1'b0;
		tick(3);
		trst_n <= 1'b1;
		tick(3);
		check("bist_tx trst", btx, 4'h0);
		check("rx_en trst", rxe, 4'h0);
		check("lfn off", lfn, 4'h0);
		latch(2, 8'h55);
		bus <= 8'h0c;
		// re-enable after all drivers off: only enables checked, not output timing
		le[0] <= 1'b1;
		tick(4);
		check("transparent", den, 8'h0c);
		bus <= 8'h81;
		tick(4);
		le[0] <= 1'b0;
		bus <= 8'hff;
		tick(4);
		check("held", den, 8'h81);
		check("pwr_dn 81", pdn, 4'h6);
		tx_set <= 4'h1;
		tick(3);
		check("out map", sop, 8'h01);
		apb(1'b0, SPEL_LATCH_ADDR, 0);
		check("latch reg", rd, 32'h0055ff81);
		// speed mid with tx clock select low keeps half rate legal
		apb(1'b1, SPEL_CTRL_ADDR, 32'h12);
		tick(3);
		check("mult half", mult, 5'd20);
		apb(1'b0, SPEL_STATUS_ADDR, 0);
		check("pdn stat", rd[SPEL_STAT_PDN_LSB +: 4], 4'h6);
		check("cfg legal", rd[SPEL_STAT_CFGERR_BIT], 0);
		// half rate at low speed is reserved and must be flagged
		apb(1'b1, SPEL_CTRL_ADDR, 32'h02);
		apb(1'b0, SPEL_STATUS_ADDR, 0);
		check("cfg reserved", rd[SPEL_STAT_CFGERR_BIT], 1);
		apb(1'b1, SPEL_CTRL_ADDR, 32'h0);
		ticks = 0;
		repeat (100) begin
			@(posedge pclk);
			ticks += tick_o;
		end
		check("char_tick", ticks, 10);
		check("mult full", mult, 5'd10);
		for (int l = 0; l < 3; l++) begin
			apb(1'b1, SPEL_CTRL_ADDR, l << 6);
			amp <= 2'(l + 1);
			tick(60);
			check("amp pass", lfn, 4'hf);
			amp <= 2'(l);
			tick(4);
			check("amp low", lfn, 4'h0);
		end
		amp <= 2'h3;
		tick(60);
		tog <= 1'b0;
		tick(50);
		check("idle 50", lfn, 4'hf);
		tick(20);
		check("idle 70", lfn, 4'h0);
		tog <= 1'b1;
		tick(15);
		check("two chars", lfn, 4'h0);
		tick(50);
		check("relock", lfn, 4'hf);
		inr <= 1'b0;
		tick(40);
		check("range", lfn, 4'h0);
		inr <= 1'b1;
		tick(40);
		check("range ok", lfn, 4'hf);
		tog <= 1'b0;
		lvl <= 1'b1;
		tick(3);
		check("rx1", cdr, 4'hf);
		apb(1'b1, SPEL_CTRL_ADDR, 32'hf80);
		tick(3);
		check("rx2", cdr, 4'h0);
		apb(1'b1, SPEL_CTRL_ADDR, 32'h1);
		tx_set <= 4'h5;
		amp <= 2'h0;
		tick(3);
		check("loop out", sop, 8'h81);
		check("loop cdr", cdr, 4'h5);
		tx_tog <= 1'b1;
		tick(70);
		check("loop lfn", lfn, 4'hf);
		test_done;
	end
endmodule : serial_port_enable_and_link_fault_tb
`default_nettype wire

//--- verif/spel_far_end.sv
// remote transmitter model that feeds both line receivers of every channel
`timescale 1ns/1ps
`default_nettype none
module spel_far_end (
	input wire logic pclk,
	input wire logic toggle,
	input wire logic level,
	input wire logic [1:0] amp,
	input wire logic in_range,
	output wire logic [3:0] line_1,
	output wire logic [3:0] line_2,
	output wire logic [7:0] amp_1,
	output wire logic [7:0] amp_2,
	output wire logic [3:0] vco_ok
);
	logic phase_q = 1'b0;
	// one bit per clock, within the selected speed range
	always @(posedge pclk) begin
		phase_q <= toggle ? ~phase_q : level;
	end
	// second receiver carries the inverse so the selected input can be told apart
	assign line_1 = {4{phase_q}};
	assign line_2 = ~line_1;
	assign amp_1 = {4{amp}};
	assign amp_2 = {4{amp}};
	assign vco_ok = {4{in_range}};
endmodule : spel_far_end
`default_nettype wire
